// File: logic/dbpt_timer.sv
// dbpt_timer: prescaled 16-bit / dual 8-bit timer (8-bit high byte counts every sys_clk) with capture and byte register port.
// assumes: oscillator ticks are one-cycle pulses synchronous to sys_clk; bus master per plain port.
////////////////////////////////////////////////////////////////////////////////////////////////
module dbpt_timer
	import dbpt_pkg::*;
#(
	parameter int LIMIT_BITS = PRESCALE_BITS
) (
	input  wire logic        sys_clk,   // system clock, 50 MHz
	input  wire logic        reset,     // synchronous reset, active high
	input  wire dbpt_bus_s   bus,       // register port request
	input  wire dbpt_ticks_s ticks,     // alternate clock source ticks
	output logic [7:0]       rdata,     // read data, cycle after read strobe
	output logic             irq,       // interrupt request to the shared vector
	output logic             low_wrap,  // low byte period pulse
	output logic             high_wrap  // high byte period pulse
);

	////////////////////////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0] low_match_data;
	logic [7:0] high_match_data;
	logic [7:0] timer_control;
	logic [7:0] divider_and_mode;
	logic [7:0] low_capture;
	logic [7:0] high_capture;

	logic wr_low;
	logic wr_high;
	logic wr_ctl;
	logic wr_div;
	assign wr_low  = bus.wr && bus.addr == ADDR_LOW_MATCH;
	assign wr_high = bus.wr && bus.addr == ADDR_HIGH_MATCH;
	assign wr_ctl  = bus.wr && bus.addr == ADDR_CONTROL;
	assign wr_div  = bus.wr && bus.addr == ADDR_DIVIDER;

	logic                  run;
	logic                  high_run_bit;
	logic                  width_sel;
	logic                  cap_en;
	logic                  read_sel;
	logic [1:0]            clock_source_select;
	logic [LIMIT_BITS-1:0] divider_limit;
	assign run                 = timer_control[CTL_RUN];
	assign high_run_bit        = timer_control[CTL_HIGH_RUN];
	assign clock_source_select = timer_control[CTL_CLOCK_SOURCE_SELECT_HI:CTL_CLOCK_SOURCE_SELECT_LO];
	assign width_sel           = divider_and_mode[DIV_WIDTH_SEL];
	assign cap_en              = divider_and_mode[DIV_CAP_EN];
	assign read_sel            = divider_and_mode[DIV_READ_SEL];
	assign divider_limit       = divider_and_mode[LIMIT_BITS-1:0];

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			low_match_data   <= RESET_BYTE;
			high_match_data  <= RESET_BYTE;
			divider_and_mode <= RESET_BYTE;
		end else begin
			if (wr_low) begin
				low_match_data <= bus.wdata;
			end
			if (wr_high) begin
				high_match_data <= bus.wdata;
			end
			if (wr_div) begin
				divider_and_mode <= bus.wdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// prescaler
	logic                  src_tick;
	logic [LIMIT_BITS-1:0] prescale;
	logic                  pre_match;

	always_comb begin
		case (dbpt_src_e'(clock_source_select))
			DBPT_SRC_SYS:  src_tick = 1'b1;
			DBPT_SRC_RC:   src_tick = ticks.rc_tick;
			DBPT_SRC_FIRST_OSCILLATOR: src_tick = ticks.first_oscillator_tick;
			DBPT_SRC_SECOND_OSCILLATOR: src_tick = ticks.second_oscillator_tick;
			default:       src_tick = 1'b0;
		endcase
	end

	assign pre_match = run && src_tick && prescale == divider_limit;

	always_ff @(posedge sys_clk) begin
		if (reset || !run) begin
			prescale <= '0;
		end else if (pre_match) begin
			prescale <= '0;
		end else if (src_tick) begin
			prescale <= prescale + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// count bytes
	logic [7:0] low_count_byte;
	logic [7:0] high_count_byte;
	logic [7:0] low_buf;
	logic [7:0] high_buf;
	logic       low_eq;
	logic       high_eq;
	logic       low_w;
	logic       high_w;
	logic       high_count_enable;
	logic       high_tick;
	logic       low_qual;
	logic       high_qual;
	logic       low_ovf;

	assign high_count_enable = width_sel ? high_run_bit : run;
	// in 16-bit mode the low byte keeps wrapping at 255 until the high byte matches too
	assign low_ovf   = run && pre_match && low_count_byte == 8'hff;
	assign high_tick = width_sel ? 1'b1 : (low_ovf || (pre_match && low_w));
	assign low_qual  = width_sel ? 1'b1 : high_eq;
	assign high_qual = width_sel ? 1'b1 : low_eq;

	dbpt_byte_counter #(
		.WIDTH (8)
	) u_low (
		.sys_clk    (sys_clk),
		.reset      (reset),
		.run        (run),
		.tick       (pre_match),
		.match_qual (low_qual),
		.match_data (low_match_data),
		.count      (low_count_byte),
		.match_buf  (low_buf),
		.at_match   (low_eq),
		.wrap       (low_w)
	);

	// 16-bit mode: high byte advances on low overflow and resets with the full match
	dbpt_byte_counter #(
		.WIDTH (8)
	) u_high (
		.sys_clk    (sys_clk),
		.reset      (reset),
		.run        (high_count_enable),
		.tick       (high_tick),
		.match_qual (high_qual),
		.match_data (high_match_data),
		.count      (high_count_byte),
		.match_buf  (high_buf),
		.at_match   (high_eq),
		.wrap       (high_w)
	);

	// period = ((high<<8) + low + 1) * (limit + 1) count clocks in 16-bit mode
	logic low_evt;
	logic high_evt;
	assign low_evt  = width_sel ? low_w : (low_w && high_w);
	assign high_evt = width_sel ? high_w : (low_w && high_w);

	////////////////////////////////////////////////////////////////////////////////////////
	// control register and flags
	logic next_low_flag;
	logic next_high_flag;

	always_comb begin
		next_low_flag  = timer_control[CTL_LOW_FLAG];
		next_high_flag = timer_control[CTL_HIGH_FLAG];
		if (wr_ctl) begin
			next_low_flag  = bus.wdata[CTL_LOW_FLAG];
			next_high_flag = bus.wdata[CTL_HIGH_FLAG];
		end
		// set wins over a software clear in the same cycle
		// in 16-bit mode both flags mark the full period
		if (low_evt) begin
			next_low_flag = 1'b1;
		end
		if (high_evt) begin
			next_high_flag = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			timer_control <= RESET_BYTE;
		end else begin
			if (wr_ctl) begin
				timer_control <= bus.wdata;
			end
			timer_control[CTL_LOW_FLAG]  <= next_low_flag;
			timer_control[CTL_HIGH_FLAG] <= next_high_flag;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// capture on rising flags
	logic low_rise;
	logic high_rise;
	assign low_rise  = next_low_flag && !timer_control[CTL_LOW_FLAG];
	assign high_rise = next_high_flag && !timer_control[CTL_HIGH_FLAG];

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			low_capture  <= RESET_BYTE;
			high_capture <= RESET_BYTE;
		end else if (cap_en) begin
			if (high_rise) begin
				low_capture <= low_count_byte;
			end
			if (width_sel ? low_rise : high_rise) begin
				high_capture <= high_count_byte;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// outputs
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			irq <= 1'b0;
		end else begin
			irq <= (next_low_flag && timer_control[CTL_LOW_IE]) ||
			       (next_high_flag && timer_control[CTL_HIGH_IE]);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			low_wrap  <= 1'b0;
			high_wrap <= 1'b0;
		end else begin
			low_wrap  <= low_evt;
			high_wrap <= high_evt;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rdata <= 8'h00;
		end else if (bus.rd) begin
			case (bus.addr)
				ADDR_LOW_MATCH:  rdata <= read_sel ? low_capture : low_match_data;
				ADDR_HIGH_MATCH: rdata <= read_sel ? high_capture : high_match_data;
				ADDR_CONTROL:    rdata <= timer_control;
				ADDR_DIVIDER:    rdata <= divider_and_mode;
				default:         rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

endmodule

// File: logic/dbpt_pkg.sv
// dbpt_pkg: constants, field positions and carrier types of the dual byte prescaled timer.
// assumes: included by every design file of the timer; 8-bit register bus with 16-bit addresses.
package dbpt_pkg;

	localparam logic [15:0] ADDR_LOW_MATCH  = 16'h7f14;
	localparam logic [15:0] ADDR_HIGH_MATCH = 16'h7f15;
	localparam logic [15:0] ADDR_CONTROL    = 16'h7f16;
	localparam logic [15:0] ADDR_DIVIDER    = 16'h7f17;

	localparam logic [7:0] RESET_BYTE = 8'h00;

	// timer_control fields
	localparam int CTL_HIGH_RUN  = 7;
	localparam int CTL_HIGH_FLAG = 6;
	localparam int CTL_HIGH_IE   = 5;
	localparam int CTL_CLOCK_SOURCE_SELECT_HI  = 4;
	localparam int CTL_CLOCK_SOURCE_SELECT_LO  = 3;
	localparam int CTL_RUN       = 2;
	localparam int CTL_LOW_FLAG  = 1;
	localparam int CTL_LOW_IE    = 0;

	// divider_and_mode fields
	localparam int DIV_READ_SEL  = 7;
	localparam int DIV_WIDTH_SEL = 6;
	localparam int DIV_CAP_EN    = 5;
	localparam int DIV_LIMIT_HI  = 4;

	localparam int PRESCALE_BITS = 5;

	typedef enum logic [1:0] {
		DBPT_SRC_SYS  = 2'h0,
		DBPT_SRC_RC   = 2'h1,
		DBPT_SRC_FIRST_OSCILLATOR = 2'h2,
		DBPT_SRC_SECOND_OSCILLATOR = 2'h3
	} dbpt_src_e;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} dbpt_bus_s;

	// clock source ticks, each a one-cycle enable synchronous to sys_clk
	typedef struct packed {
		logic rc_tick;
		logic first_oscillator_tick;
		logic second_oscillator_tick;
	} dbpt_ticks_s;

endpackage

// File: logic/dbpt_byte_counter.sv
// dbpt_byte_counter: one 8-bit count byte with its match buffer.
// assumes: run, tick and match_qual come from the timer core in the same clock domain.
module dbpt_byte_counter
	import dbpt_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input  wire logic             sys_clk,    // system clock
	input  wire logic             reset,      // synchronous reset, active high
	input  wire logic             run,        // counter runs
	input  wire logic             tick,       // count enable for this cycle
	input  wire logic             match_qual, // other byte also matches (16-bit mode)
	input  wire logic [WIDTH-1:0] match_data, // software match value
	output logic      [WIDTH-1:0] count,      // current count
	output logic      [WIDTH-1:0] match_buf,  // buffered match value
	output logic                  at_match,   // count equals buffer (combinational)
	output logic                  wrap        // counter returns to zero this cycle
);

	assign at_match = (count == match_buf);
	assign wrap     = run && tick && at_match && match_qual;

	always_ff @(posedge sys_clk) begin
		if (reset || !run) begin
			count <= '0;
		end else if (wrap) begin
			count <= '0;
		end else if (tick) begin
			count <= count + 1'b1;
		end
	end

	// buffer follows data while stopped; while running it reloads only at zero
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			match_buf <= '0;
		end else if (!run || count == '0) begin
			match_buf <= match_data;
		end
	end

endmodule

// File: dv/dbpt_timer_checker.sv
// dbpt_timer_checker: port-level assertions for the dual byte prescaled timer.
// assumes: bound to dbpt_timer; software-only control and divider bits are shadowed from bus writes.
module dbpt_timer_checker
	import dbpt_pkg::*;
(
	input wire logic       sys_clk,   // system clock
	input wire logic       reset,     // synchronous reset, active high
	input wire dbpt_bus_s  bus,       // register port request
	input wire logic [7:0] rdata,     // read data
	input wire logic       irq,       // interrupt request
	input wire logic       low_wrap,  // low byte period pulse
	input wire logic       high_wrap  // high byte period pulse
);
	logic [7:0] sh_ctl;
	logic [7:0] sh_div;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);

	////////////////////////////////////////////////////////////////////////////////
	// shadow of bits that only software changes
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sh_ctl <= 8'h00;
			sh_div <= 8'h00;
		end else if (bus.wr && bus.addr == ADDR_CONTROL) begin
			sh_ctl <= bus.wdata;
		end else if (bus.wr && bus.addr == ADDR_DIVIDER) begin
			sh_div <= bus.wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	rd_idle_zero_a: assert property (!bus.rd |=> rdata == 8'h00)
		else $error("rdata not zero outside a read");
	unmapped_zero_a: assert property (bus.rd && (bus.addr < ADDR_LOW_MATCH || bus.addr > ADDR_DIVIDER)
		|=> rdata == 8'h00) else $error("unmapped read not zero");
	div_read_a: assert property (bus.rd && bus.addr == ADDR_DIVIDER |=> rdata == $past(sh_div))
		else $error("divider readback wrong");
	ctl_read_a: assert property (bus.rd && bus.addr == ADDR_CONTROL
		|=> (rdata & 8'hbd) == ($past(sh_ctl) & 8'hbd)) else $error("control readback wrong");
	stop_quiet_a: assert property ((!sh_ctl[2] && !sh_ctl[7]) [*3] |-> !low_wrap && !high_wrap)
		else $error("period pulse while stopped");
	wide_pair_a: assert property ((!sh_div[6]) [*3] |-> low_wrap == high_wrap)
		else $error("16-bit pulses not paired");
	irq_off_a: assert property ((!sh_ctl[0] && !sh_ctl[5]) [*2] |-> !irq)
		else $error("irq with both enables clear");
	irq_cause_a: assert property ($rose(irq) |-> $past(sh_ctl[0] || sh_ctl[5]))
		else $error("irq rose without an enable");
endmodule

bind dbpt_timer dbpt_timer_checker u_chk (.sys_clk(sys_clk), .reset(reset), .bus(bus), .rdata(rdata),
	.irq(irq), .low_wrap(low_wrap), .high_wrap(high_wrap));

// File: dv/dbpt_timer_tb.sv
// dbpt_timer_tb: self-checking bench for the dual byte prescaled timer.
// assumes: design and checker compiled first; alternate source ticks are made here.
module dbpt_timer_tb
	import dbpt_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk = 1'b0;
	logic        reset = 1'b1;
	dbpt_bus_s   bus = '0;
	dbpt_ticks_s ticks = '0;
	logic [7:0]  rdata;
	logic        irq;
	logic        low_wrap;
	logic        high_wrap;
	int          error_cnt = 0;
	int          n_checks = 0;
	int          tc = 0;
	logic [7:0]  v;

	dbpt_timer DUT (.sys_clk(sys_clk), .reset(reset), .bus(bus), .ticks(ticks), .rdata(rdata), .irq(irq),
		.low_wrap(low_wrap), .high_wrap(high_wrap));

	initial begin
		forever #10 sys_clk = ~sys_clk;
	end

	// periodic source ticks: every 2, 3 and 5 cycles
	always @(posedge sys_clk) begin
		tc <= tc + 1;
		ticks.rc_tick <= (tc % 2 == 0);
		ticks.first_oscillator_tick <= (tc % 3 == 0);
		ticks.second_oscillator_tick <= (tc % 5 == 0);
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		if (error_cnt == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			$display("[ERR] %s exp %h got %h", nm, e, g);
			error_cnt++;
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		bus.wr <= 1'b0;
	endtask

	task automatic rchk(input string nm, input logic [15:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		bus.rd <= 1'b0;
		#1;
		chk(nm, {8'h00, e}, {8'h00, rdata});
	endtask

	task automatic cfg(input logic [7:0] dv, input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] ct);
		wr(ADDR_CONTROL, 8'h00);
		wr(ADDR_DIVIDER, dv);
		wr(ADDR_LOW_MATCH, lo);
		wr(ADDR_HIGH_MATCH, hi);
		wr(ADDR_CONTROL, ct);
	endtask

	// cycles between two successive period pulses
	task automatic pchk(input string nm, input bit hi, input logic [15:0] e);
		int f;
		int p;
		f = -1;
		p = 0;
		for (int k = 0; k < 3000; k++) begin
			@(posedge sys_clk);
			#1;
			if (hi ? high_wrap : low_wrap) begin
				if (f >= 0) begin
					p = k - f;
					break;
				end
				f = k;
			end
		end
		if (p == 0) begin
			$display("[ERR] %s exp %0d got none", nm, e);
			error_cnt++;
			summarize();
		end else begin
			chk(nm, e, p[15:0]);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rchk("low_match_data", ADDR_LOW_MATCH, 8'h00);
		rchk("timer_control", ADDR_CONTROL, 8'h00);
		rchk("divider_and_mode", ADDR_DIVIDER, 8'h00);
		rchk("unmapped", 16'h7f18, 8'h00);
		wr(ADDR_HIGH_MATCH, 8'ha5);
		rchk("high_match_data", ADDR_HIGH_MATCH, 8'ha5);
	endtask

	task automatic t_sources();
		int per[4] = '{1, 2, 3, 5};
		for (int s = 0; s < 4; s++) begin
			cfg(8'h40, 8'h01, 8'h00, 8'h04 | 8'(s << 3));
			pchk("source period", 1'b0, 16'(2 * per[s]));
		end
	endtask

	task automatic t_wide();
		cfg(8'h02, 8'h03, 8'h00, 8'h04);
		pchk("wide short", 1'b0, 16'd12);
		rchk("wide flags", ADDR_CONTROL, 8'h46);
		cfg(8'h00, 8'h00, 8'h01, 8'h04);
		pchk("wide long", 1'b1, 16'd257);
	endtask

	task automatic t_eight();
		cfg(8'h41, 8'h02, 8'h04, 8'h84);
		pchk("low 8-bit", 1'b0, 16'd6);
		pchk("high 8-bit", 1'b1, 16'd5);
		cfg(8'h41, 8'h02, 8'h04, 8'h80);
		pchk("high alone", 1'b1, 16'd5);
	endtask

	task automatic t_irq();
		cfg(8'h40, 8'h03, 8'h00, 8'h04);
		repeat (12) @(posedge sys_clk);
		rchk("low flag", ADDR_CONTROL, 8'h06);
		chk("masked irq", 16'h0, {15'h0, irq});
		wr(ADDR_CONTROL, 8'h03);
		repeat (2) @(posedge sys_clk);
		#1;
		chk("low irq", 16'h1, {15'h0, irq});
		wr(ADDR_CONTROL, 8'h01);
		repeat (2) @(posedge sys_clk);
		#1;
		chk("cleared irq", 16'h0, {15'h0, irq});
		wr(ADDR_CONTROL, 8'h60);
		repeat (2) @(posedge sys_clk);
		#1;
		chk("high irq", 16'h1, {15'h0, irq});
	endtask

	task automatic t_cap();
		cfg(8'hbf, 8'hff, 8'hff, 8'h04);
		repeat (112) @(posedge sys_clk);
		wr(ADDR_CONTROL, 8'h44);
		rchk("low capture", ADDR_LOW_MATCH, 8'h03);
		rchk("high capture", ADDR_HIGH_MATCH, 8'h00);
		wr(ADDR_DIVIDER, 8'h9f);
		wr(ADDR_CONTROL, 8'h04);
		repeat (64) @(posedge sys_clk);
		wr(ADDR_CONTROL, 8'h44);
		rchk("held capture", ADDR_LOW_MATCH, 8'h03);
		wr(ADDR_DIVIDER, 8'h1f);
		rchk("data view", ADDR_LOW_MATCH, 8'hff);
	endtask

	// 8-bit capture: low byte at the high flag rise, high byte at the low flag rise
	task automatic t_cap8();
		cfg(8'he0, 8'h09, 8'h03, 8'h84);
		repeat (12) @(posedge sys_clk);
		rchk("low capture 8-bit", ADDR_LOW_MATCH, 8'h03);
		rchk("high capture 8-bit", ADDR_HIGH_MATCH, 8'h01);
	endtask

	// reset in mid-run returns control, divider, low match data and irq to idle
	task automatic t_rerun();
		cfg(8'h40, 8'h03, 8'h02, 8'h85);
		repeat (8) @(posedge sys_clk);
		reset <= 1'b1;
		repeat (3) @(posedge sys_clk);
		reset <= 1'b0;
		rchk("control after reset", ADDR_CONTROL, 8'h00);
		rchk("divider after reset", ADDR_DIVIDER, 8'h00);
		rchk("low data after reset", ADDR_LOW_MATCH, 8'h00);
		chk("irq after reset", 16'h0, {15'h0, irq});
	endtask

	initial begin
		repeat (10) @(posedge sys_clk);
		reset <= 1'b0;
		t_reset();
		t_sources();
		t_wide();
		t_eight();
		t_irq();
		t_cap();
		t_cap8();
		t_rerun();
		summarize();
	end
endmodule
